// ---- rtl/pfrd_pkg.sv ----
// Summary of operation
// - Reference divider is a 14-bit counter on reference input; output drives PFD reference side.
// - Reference division accepts 1 to 16383; programmed zero divides by one.
// - Reference value is upper six bits at ref_divider_upper[5:0] and lower eight at ref_divider_lower[7:0].
// - Feedback divider: 3-bit prescaler code, 6-bit swallow and 13-bit main counter, oscillator clocked.
// - Mode prescaler_and_bypass_ctrl[4:2]: 000/001/111 fixed 1/2/3; 010..110 dual 2/3 to 32/33.
// - Fixed modes ignore the swallow counter; division is ratio times main value.
// - Dual modulus division equals prescaler value times main value plus swallow value.
// - Bypass bit prescaler_and_bypass_ctrl[6] makes main counter divide by one, only in fixed modes.
// - Swallow and main have own reset bit; pll_counter_reset[0] resets all three counters.
// - Only the oscillator input clocks the feedback divider, never another source.
// - distribution_input_select[0] zero routes oscillator input to distribution; default first input.
package pfrd_pkg;

  // Register indexes; byte address is index times four
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] IDX_CNT_RESET = 8'h09;
  localparam logic [7:0] IDX_PRESCALE = 8'h0a;
  localparam logic [7:0] IDX_REF_UPPER = 8'h0b;
  localparam logic [7:0] IDX_REF_LOWER = 8'h0c;
  localparam logic [7:0] IDX_DIST_SEL = 8'h45;
  localparam logic [7:0] IDX_SWALLOW = 8'h50;
  localparam logic [7:0] IDX_MAIN_LOWER = 8'h51;
  localparam logic [7:0] IDX_MAIN_UPPER = 8'h52;
  localparam logic [7:0] IDX_AB_RESET = 8'h53;
  localparam logic [7:0] IDX_STATUS = 8'h54;

  // Field positions
  localparam int SHARED_RST_BIT = 0;
  localparam int AB_RST_BIT = 0;
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 4;
  localparam int BYPASS_BIT = 6;
  localparam int DIST_SEL_BIT = 0;
  localparam int STAT_PHASE_BIT = 13;
  localparam int STAT_DIST_BIT = 14;

  // Widths
  localparam int REF_DIV_W = 14;
  localparam int REF_UPPER_W = 6;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_W = 13;
  localparam int MAIN_UPPER_W = 5;
  localparam int PRE_W = 6;
  localparam int PIN_N = 4;

  // Reset values
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic RST_BYPASS = 1'h0;
  localparam logic RST_CNT_RESET = 1'h0;
  localparam logic RST_DIST_SEL = 1'h1;
  localparam logic [REF_DIV_W-1:0] RST_REF_DIV = 14'h0000;
  localparam logic [SWALLOW_W-1:0] RST_SWALLOW = 6'h00;
  localparam logic [MAIN_W-1:0] RST_MAIN = 13'h0000;

  // Prescaler mode codes
  localparam logic [2:0] MODE_FIX1 = 3'h0;
  localparam logic [2:0] MODE_FIX2 = 3'h1;
  localparam logic [2:0] MODE_DUAL2 = 3'h2;
  localparam logic [2:0] MODE_DUAL4 = 3'h3;
  localparam logic [2:0] MODE_DUAL8 = 3'h4;
  localparam logic [2:0] MODE_DUAL16 = 3'h5;
  localparam logic [2:0] MODE_DUAL32 = 3'h6;
  localparam logic [2:0] MODE_FIX3 = 3'h7;

  typedef enum logic {PH_SWALLOW, PH_PLAIN} pfrd_phase_t;

  // Base ratio P (fixed ratio in fixed modes)
  function automatic logic [PRE_W-1:0] pfrd_base_ratio(input logic [2:0] mode);
    case (mode)
      MODE_FIX1: pfrd_base_ratio = 6'h01;
      MODE_FIX2: pfrd_base_ratio = 6'h02;
      MODE_DUAL2: pfrd_base_ratio = 6'h02;
      MODE_DUAL4: pfrd_base_ratio = 6'h04;
      MODE_DUAL8: pfrd_base_ratio = 6'h08;
      MODE_DUAL16: pfrd_base_ratio = 6'h10;
      MODE_DUAL32: pfrd_base_ratio = 6'h20;
      default: pfrd_base_ratio = 6'h03;
    endcase
  endfunction

  function automatic logic pfrd_is_dual(input logic [2:0] mode);
    pfrd_is_dual = (mode != MODE_FIX1) && (mode != MODE_FIX2) && (mode != MODE_FIX3);
  endfunction

endpackage

// ---- rtl/pfrd_ref_if.sv ----
`timescale 1ns/100ps
interface pfrd_ref_if;
  import pfrd_pkg::*;
  logic refEdge;
  logic cntReset;
  logic [REF_DIV_W-1:0] divValue;
  logic divPulse;
  modport host (output refEdge, output cntReset, output divValue, input divPulse);
  modport divider (input refEdge, input cntReset, input divValue, output divPulse);
endinterface

// ---- rtl/pfrd_ref_divider.sv ----
`timescale 1ns/100ps
module pfrd_ref_divider
  import pfrd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control and divided output
  pfrd_ref_if.divider refBus
);

  logic [REF_DIV_W-1:0] refCount;
  logic [REF_DIV_W-1:0] next_refCount;
  logic divPulse;
  logic next_divPulse;
  logic [REF_DIV_W:0] refInc;
  logic [REF_DIV_W:0] refTarget;

  assign refInc = {1'h0, refCount} + {{REF_DIV_W{1'h0}}, 1'h1};
  // Zero behaves as a division by one
  assign refTarget = (refBus.divValue == RST_REF_DIV) ? {{REF_DIV_W{1'h0}}, 1'h1} : {1'h0, refBus.divValue};

  always_comb begin
    next_refCount = refCount;
    next_divPulse = 1'h0;
    if (refBus.cntReset) begin
      next_refCount = RST_REF_DIV;
    end else if (refBus.refEdge) begin
      if (refInc >= refTarget) begin
        next_refCount = RST_REF_DIV;
        next_divPulse = 1'h1;
      end else begin
        next_refCount = refInc[REF_DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      refCount <= RST_REF_DIV;
      divPulse <= 1'h0;
    end else begin
      refCount <= next_refCount;
      divPulse <= next_divPulse;
    end
  end

  assign refBus.divPulse = divPulse;

endmodule

// ---- rtl/pfrd_pll_dividers.sv ----
`timescale 1ns/100ps
module pfrd_pll_dividers
  import pfrd_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic reference_clock_input,
  input wire logic reference_clock_input_complement,
  input wire logic first_clock_input,
  input wire logic oscillator_clock_input,
  // Divided outputs and distribution
  output logic pfdReferencePulse,
  output logic pfdFeedbackPulse,
  output logic distributionClock
);

  // Pin synchronisers
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] syncStage1;
  logic [PIN_N-1:0] syncStage2;
  logic [PIN_N-1:0] next_syncStage1;
  logic [PIN_N-1:0] next_syncStage2;
  logic refLevel;
  logic refLevelPrev;
  logic next_refLevelPrev;
  logic oscLevelPrev;
  logic next_oscLevelPrev;
  logic refEdge;
  logic oscEdge;

  assign pinRaw = {oscillator_clock_input, first_clock_input,
                   reference_clock_input_complement, reference_clock_input};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_comb begin
        next_syncStage1[gi] = pinRaw[gi];
        next_syncStage2[gi] = syncStage1[gi];
      end
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          syncStage1[gi] <= 1'h0;
          syncStage2[gi] <= 1'h0;
        end else begin
          syncStage1[gi] <= next_syncStage1[gi];
          syncStage2[gi] <= next_syncStage2[gi];
        end
      end
    end
  endgenerate

  // Differential reference resolved after synchronisation
  assign refLevel = syncStage2[0] & ~syncStage2[1];
  assign refEdge = refLevel & ~refLevelPrev;
  // Feedback edges come only from the oscillator pin
  assign oscEdge = syncStage2[3] & ~oscLevelPrev;

  always_comb begin
    next_refLevelPrev = refLevel;
    next_oscLevelPrev = syncStage2[3];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      refLevelPrev <= 1'h0;
      oscLevelPrev <= 1'h0;
    end else begin
      refLevelPrev <= next_refLevelPrev;
      oscLevelPrev <= next_oscLevelPrev;
    end
  end

  // Control registers
  logic sharedReset;
  logic abReset;
  logic [2:0] prescaleMode;
  logic bypass;
  logic [REF_UPPER_W-1:0] refUpper;
  logic [7:0] refLower;
  logic distSel;
  logic [SWALLOW_W-1:0] swallowDiv;
  logic [7:0] mainLower;
  logic [MAIN_UPPER_W-1:0] mainUpper;
  logic next_sharedReset;
  logic next_abReset;
  logic [2:0] next_prescaleMode;
  logic next_bypass;
  logic [REF_UPPER_W-1:0] next_refUpper;
  logic [7:0] next_refLower;
  logic next_distSel;
  logic [SWALLOW_W-1:0] next_swallowDiv;
  logic [7:0] next_mainLower;
  logic [MAIN_UPPER_W-1:0] next_mainUpper;

  // APB decode
  logic [ADDR_W-ADDR_LSB-1:0] regIdx;
  logic aligned;
  logic mapped;
  logic writeEn;
  logic setupPhase;
  logic [31:0] readValue;
  logic [31:0] next_prdata;

  assign regIdx = paddr[ADDR_W-1:ADDR_LSB];
  assign aligned = (paddr[ADDR_LSB-1:0] == '0);
  assign setupPhase = psel & ~penable;
  assign writeEn = psel & penable & pwrite & mapped;
  assign pready = 1'h1;
  assign pslverr = psel & penable & ~mapped;

  // Status fields
  logic [MAIN_W-1:0] mainCount;
  pfrd_phase_t phase;

  always_comb begin
    mapped = aligned;
    readValue = 32'h0000_0000;
    // Only aligned words at known indexes are mapped; other bits read zero
    case (regIdx)
      (ADDR_W-ADDR_LSB)'(IDX_CNT_RESET): readValue[SHARED_RST_BIT] = sharedReset;
      (ADDR_W-ADDR_LSB)'(IDX_PRESCALE): begin
        readValue[MODE_MSB:MODE_LSB] = prescaleMode;
        readValue[BYPASS_BIT] = bypass;
      end
      (ADDR_W-ADDR_LSB)'(IDX_REF_UPPER): readValue[REF_UPPER_W-1:0] = refUpper;
      (ADDR_W-ADDR_LSB)'(IDX_REF_LOWER): readValue[7:0] = refLower;
      (ADDR_W-ADDR_LSB)'(IDX_DIST_SEL): readValue[DIST_SEL_BIT] = distSel;
      (ADDR_W-ADDR_LSB)'(IDX_SWALLOW): readValue[SWALLOW_W-1:0] = swallowDiv;
      (ADDR_W-ADDR_LSB)'(IDX_MAIN_LOWER): readValue[7:0] = mainLower;
      (ADDR_W-ADDR_LSB)'(IDX_MAIN_UPPER): readValue[MAIN_UPPER_W-1:0] = mainUpper;
      (ADDR_W-ADDR_LSB)'(IDX_AB_RESET): readValue[AB_RST_BIT] = abReset;
      (ADDR_W-ADDR_LSB)'(IDX_STATUS): begin
        readValue[MAIN_W-1:0] = mainCount;
        readValue[STAT_PHASE_BIT] = (phase == PH_SWALLOW);
        readValue[STAT_DIST_BIT] = distSel;
      end
      default: mapped = 1'h0;
    endcase
  end

  always_comb begin
    next_prdata = prdata;
    if (setupPhase && !pwrite) begin
      next_prdata = mapped ? readValue : 32'h0000_0000;
    end
  end

  always_comb begin
    next_sharedReset = sharedReset;
    next_abReset = abReset;
    next_prescaleMode = prescaleMode;
    next_bypass = bypass;
    next_refUpper = refUpper;
    next_refLower = refLower;
    next_distSel = distSel;
    next_swallowDiv = swallowDiv;
    next_mainLower = mainLower;
    next_mainUpper = mainUpper;
    if (writeEn) begin
      case (regIdx)
        (ADDR_W-ADDR_LSB)'(IDX_CNT_RESET): next_sharedReset = pwdata[SHARED_RST_BIT];
        (ADDR_W-ADDR_LSB)'(IDX_PRESCALE): begin
          next_prescaleMode = pwdata[MODE_MSB:MODE_LSB];
          next_bypass = pwdata[BYPASS_BIT];
        end
        (ADDR_W-ADDR_LSB)'(IDX_REF_UPPER): next_refUpper = pwdata[REF_UPPER_W-1:0];
        (ADDR_W-ADDR_LSB)'(IDX_REF_LOWER): next_refLower = pwdata[7:0];
        (ADDR_W-ADDR_LSB)'(IDX_DIST_SEL): next_distSel = pwdata[DIST_SEL_BIT];
        (ADDR_W-ADDR_LSB)'(IDX_SWALLOW): next_swallowDiv = pwdata[SWALLOW_W-1:0];
        (ADDR_W-ADDR_LSB)'(IDX_MAIN_LOWER): next_mainLower = pwdata[7:0];
        (ADDR_W-ADDR_LSB)'(IDX_MAIN_UPPER): next_mainUpper = pwdata[MAIN_UPPER_W-1:0];
        (ADDR_W-ADDR_LSB)'(IDX_AB_RESET): next_abReset = pwdata[AB_RST_BIT];
        default: next_abReset = abReset;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sharedReset <= RST_CNT_RESET;
      abReset <= RST_CNT_RESET;
      prescaleMode <= RST_MODE;
      bypass <= RST_BYPASS;
      refUpper <= RST_REF_DIV[REF_DIV_W-1:8];
      refLower <= RST_REF_DIV[7:0];
      distSel <= RST_DIST_SEL;
      swallowDiv <= RST_SWALLOW;
      mainLower <= RST_MAIN[7:0];
      mainUpper <= RST_MAIN[MAIN_W-1:8];
      prdata <= 32'h0000_0000;
    end else begin
      sharedReset <= next_sharedReset;
      abReset <= next_abReset;
      prescaleMode <= next_prescaleMode;
      bypass <= next_bypass;
      refUpper <= next_refUpper;
      refLower <= next_refLower;
      distSel <= next_distSel;
      swallowDiv <= next_swallowDiv;
      mainLower <= next_mainLower;
      mainUpper <= next_mainUpper;
      prdata <= next_prdata;
    end
  end

  // Reference divider
  pfrd_ref_if refBus ();

  assign refBus.refEdge = refEdge;
  assign refBus.cntReset = sharedReset;
  assign refBus.divValue = {refUpper, refLower};
  assign pfdReferencePulse = refBus.divPulse;

  pfrd_ref_divider u_refDivider (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .refBus(refBus.divider)
  );

  // Feedback divider: prescaler, swallow and main counters
  logic [PRE_W-1:0] preCount;
  logic [SWALLOW_W-1:0] swallowCount;
  logic [PRE_W-1:0] next_preCount;
  logic [SWALLOW_W-1:0] next_swallowCount;
  logic [MAIN_W-1:0] next_mainCount;
  pfrd_phase_t next_phase;
  logic fbPulse;
  logic next_fbPulse;
  logic dualMode;
  logic bypassActive;
  logic [MAIN_W-1:0] mainDiv;
  logic [MAIN_W:0] mainTarget;
  logic [PRE_W:0] modulus;
  logic [PRE_W:0] preInc;
  logic [MAIN_W:0] mainInc;
  logic [SWALLOW_W:0] swallowInc;
  pfrd_phase_t startPhase;

  assign dualMode = pfrd_is_dual(prescaleMode);
  assign bypassActive = bypass & ~dualMode;
  assign mainDiv = {mainUpper, mainLower};
  assign mainTarget = bypassActive ? {{MAIN_W{1'h0}}, 1'h1} : {1'h0, mainDiv};
  // P+1 during the swallow phase, P otherwise; fixed modes never swallow
  assign modulus = (dualMode && phase == PH_SWALLOW) ?
                   {1'h0, pfrd_base_ratio(prescaleMode)} + {{PRE_W{1'h0}}, 1'h1} :
                   {1'h0, pfrd_base_ratio(prescaleMode)};
  assign preInc = {1'h0, preCount} + {{PRE_W{1'h0}}, 1'h1};
  assign mainInc = {1'h0, mainCount} + {{MAIN_W{1'h0}}, 1'h1};
  assign swallowInc = {1'h0, swallowCount} + {{SWALLOW_W{1'h0}}, 1'h1};
  assign startPhase = (dualMode && swallowDiv != RST_SWALLOW) ? PH_SWALLOW : PH_PLAIN;

  always_comb begin
    next_preCount = preCount;
    next_swallowCount = swallowCount;
    next_mainCount = mainCount;
    next_phase = phase;
    next_fbPulse = 1'h0;
    if (sharedReset || abReset) begin
      next_preCount = '0;
      next_swallowCount = RST_SWALLOW;
      next_mainCount = RST_MAIN;
      next_phase = startPhase;
    end else if (oscEdge && mainTarget != '0) begin
      if (preInc >= modulus) begin
        next_preCount = '0;
        if (mainInc >= mainTarget) begin
          // Cycle complete: prescaler, main and swallow counters reload
          next_fbPulse = 1'h1;
          next_mainCount = RST_MAIN;
          next_swallowCount = RST_SWALLOW;
          next_phase = startPhase;
        end else begin
          next_mainCount = mainInc[MAIN_W-1:0];
          case (phase)
            PH_SWALLOW: begin
              if (swallowInc >= {1'h0, swallowDiv}) begin
                next_phase = PH_PLAIN;
                next_swallowCount = RST_SWALLOW;
              end else begin
                next_swallowCount = swallowInc[SWALLOW_W-1:0];
              end
            end
            PH_PLAIN: next_phase = PH_PLAIN;
            default: next_phase = PH_PLAIN;
          endcase
        end
      end else begin
        next_preCount = preInc[PRE_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      preCount <= '0;
      swallowCount <= RST_SWALLOW;
      mainCount <= RST_MAIN;
      phase <= PH_PLAIN;
      fbPulse <= 1'h0;
    end else begin
      preCount <= next_preCount;
      swallowCount <= next_swallowCount;
      mainCount <= next_mainCount;
      phase <= next_phase;
      fbPulse <= next_fbPulse;
    end
  end

  assign pfdFeedbackPulse = fbPulse;

  // Distribution input select
  logic next_distributionClock;

  always_comb begin
    next_distributionClock = distSel ? syncStage2[2] : syncStage2[3];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      distributionClock <= 1'h0;
    end else begin
      distributionClock <= next_distributionClock;
    end
  end

endmodule

// ---- dv/pfrd_pll_dividers_checker.sv ----
`timescale 1ns/100ps
module pfrd_pll_dividers_checker
  import pfrd_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and divided outputs
  input wire logic reference_clock_input,
  input wire logic reference_clock_input_complement,
  input wire logic first_clock_input,
  input wire logic oscillator_clock_input,
  input wire logic pfdReferencePulse,
  input wire logic pfdFeedbackPulse,
  input wire logic distributionClock
);
  typedef struct packed {
    logic refPrev; logic oscPrev; logic firstPrev; logic sharedRst; logic abRst;
    logic [3:0] refAge; logic [3:0] oscAge; logic [3:0] pinAge; logic [3:0] rstAge; logic [3:0] abAge;
  } pfrd_chk_t;
  pfrd_chk_t st, next_st;
  logic refLvl, mapped, wrTaken;
  logic [ADDR_W-3:0] idx;

  function automatic logic [3:0] sat(input logic [3:0] a);
    return (a == 4'hf) ? a : a + 4'h1;
  endfunction

  assign refLvl = reference_clock_input & ~reference_clock_input_complement;
  assign idx = paddr[ADDR_W-1:ADDR_LSB];
  assign mapped = (paddr[1:0] == 2'b00) && (idx inside {IDX_CNT_RESET, IDX_PRESCALE, IDX_REF_UPPER,
    IDX_REF_LOWER, IDX_DIST_SEL, IDX_SWALLOW, IDX_MAIN_LOWER, IDX_MAIN_UPPER, IDX_AB_RESET, IDX_STATUS});
  assign wrTaken = psel & penable & pwrite & pready & mapped;

  // Ages count cycles since a pin edge, a select write or a held counter reset
  always_comb begin
    next_st = st;
    next_st.refPrev = refLvl;
    next_st.oscPrev = oscillator_clock_input;
    next_st.firstPrev = first_clock_input;
    if (wrTaken && idx == IDX_CNT_RESET) next_st.sharedRst = pwdata[0];
    if (wrTaken && idx == IDX_AB_RESET) next_st.abRst = pwdata[0];
    next_st.refAge = (refLvl && !st.refPrev) ? 4'h0 : sat(st.refAge);
    next_st.oscAge = (oscillator_clock_input && !st.oscPrev) ? 4'h0 : sat(st.oscAge);
    next_st.pinAge = (oscillator_clock_input != st.oscPrev || first_clock_input != st.firstPrev
      || (wrTaken && idx == IDX_DIST_SEL)) ? 4'h0 : sat(st.pinAge);
    next_st.rstAge = st.sharedRst ? sat(st.rstAge) : 4'h0;
    next_st.abAge = (st.abRst || st.sharedRst) ? sat(st.abAge) : 4'h0;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) st <= '0;
    else st <= next_st;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_access;
    psel && penable;
  endsequence
  sequence s_ref_rest;
    !pfdReferencePulse [*3];
  endsequence
  sequence s_fb_rest;
    !pfdFeedbackPulse [*3];
  endsequence

  a_ready_always: assert property (psel |-> pready) else $error("pready low in transfer");
  a_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr) else $error("no error on unmapped access");
  a_err_mapped: assert property (s_access ##0 mapped |-> !pslverr) else $error("error on mapped access");
  a_ref_single: assert property ($rose(pfdReferencePulse) |=> s_ref_rest)
    else $error("reference pulse not single");
  a_fb_single: assert property ($rose(pfdFeedbackPulse) |=> s_fb_rest)
    else $error("feedback pulse not single");
  a_ref_from_pin: assert property (pfdReferencePulse |-> st.refAge inside {[1:7]})
    else $error("reference pulse without reference edge");
  a_fb_from_osc: assert property (pfdFeedbackPulse |-> st.oscAge inside {[1:7]})
    else $error("feedback pulse without oscillator edge");
  a_dist_from_pin: assert property ($changed(distributionClock) |-> st.pinAge <= 4'h7)
    else $error("distribution changed without cause");
  a_shared_quiet: assert property (st.rstAge >= 4'h8 |-> !pfdReferencePulse && !pfdFeedbackPulse)
    else $error("pulse while shared reset held");
  a_own_quiet: assert property (st.abAge >= 4'h8 |-> !pfdFeedbackPulse)
    else $error("feedback pulse while counter reset held");
endmodule

// ---- dv/pfrd_clock_source.sv ----
`timescale 1ns/100ps
module pfrd_clock_source #(
  parameter int REF_HALF = 3,
  parameter int OSC_HALF = 3,
  parameter int FIRST_HALF = 5
)
(
  // Timing base
  input wire logic ref_clk,
  // Pin drive
  output logic refP,
  output logic refN,
  output logic firstClk,
  output logic oscClk
);
  int refCnt = 0;
  int oscCnt = 0;
  int firstCnt = 0;
  initial begin
    refP = 1'b0;
    oscClk = 1'b0;
    firstClk = 1'b0;
  end
  assign refN = ~refP;
  // Every level lasts at least two sampling cycles, keeping all three rates legal
  always @(posedge ref_clk) begin
    refCnt <= (refCnt == REF_HALF - 1) ? 0 : refCnt + 1;
    oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
    firstCnt <= (firstCnt == FIRST_HALF - 1) ? 0 : firstCnt + 1;
    if (refCnt == REF_HALF - 1) refP <= ~refP;
    if (oscCnt == OSC_HALF - 1) oscClk <= ~oscClk;
    if (firstCnt == FIRST_HALF - 1) firstClk <= ~firstClk;
  end
endmodule

// ---- dv/pfrd_pll_dividers_bench.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module pfrd_pll_dividers_bench;
  import pfrd_pkg::*;
  localparam int ADDR_W = 12;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, refP, refN, firstClk, oscClk, refPulse, fbPulse, distClk;
  int num_errors = 0, cmp_count = 0, cycles = 0;

  always #5ns ref_clk = ~ref_clk;

  pfrd_clock_source u_src (.ref_clk(ref_clk), .refP(refP), .refN(refN), .firstClk(firstClk), .oscClk(oscClk));
  pfrd_pll_dividers #(.ADDR_W(ADDR_W)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_input(refP), .reference_clock_input_complement(refN), .first_clock_input(firstClk),
    .oscillator_clock_input(oscClk), .pfdReferencePulse(refPulse), .pfdFeedbackPulse(fbPulse),
    .distributionClock(distClk));

  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      close_out();
    end
  end

  function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] i);
    return ADDR_W'(i) << ADDR_LSB;
  endfunction

  function automatic int fbExp(input logic [2:0] m, input logic b, input int mn, input int sw);
    case (m)
      3'b000: return b ? 1 : mn;
      3'b001: return b ? 2 : 2 * mn;
      3'b111: return b ? 3 : 3 * mn;
      default: return (2 << (m - 3'b010)) * mn + sw;
    endcase
  endfunction

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, byteAddr(i), d, rd, er);
  endtask

  // Cycles between the second and third rising events of the watched output
  task automatic gap(input int w, output int n);
    int ev;
    logic p, c;
    ev = 0;
    n = 0;
    p = 1'b1;
    while (ev < 3) begin
      @(negedge ref_clk);
      c = (w == 0) ? refPulse : (w == 1) ? fbPulse : distClk;
      n++;
      if (c === 1'b1 && p !== 1'b1) begin
        ev++;
        if (ev < 3) n = 0;
      end
      p = c;
    end
  endtask

  task automatic count(output int rc, output int fc);
    rc = 0;
    fc = 0;
    repeat (8) @(negedge ref_clk);
    repeat (400) begin
      @(negedge ref_clk);
      rc += (refPulse === 1'b1);
      fc += (fbPulse === 1'b1);
    end
  endtask

  initial begin
    int n, k, r, mn, sw, rc, fc;
    logic [31:0] rd;
    logic er;
    logic [2:0] m;
    logic b;
    logic ph;
    k = $urandom(15552);
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, byteAddr(IDX_DIST_SEL), 32'h0, rd, er); `CHK(rd, 32'h1)
    apb(1'b0, byteAddr(IDX_PRESCALE), 32'h0, rd, er); `CHK(rd, 32'h0)
    apb(1'b0, 12'h080, 32'h0, rd, er); `CHK({er, rd}, 33'h100000000)
    apb(1'b1, byteAddr(IDX_PRESCALE) + 12'h1, 32'hff, rd, er); `CHK(er, 1'b1)
    apb(1'b0, byteAddr(IDX_PRESCALE), 32'h0, rd, er); `CHK(rd, 32'h0)
    wr(IDX_PRESCALE, 32'hff);
    apb(1'b0, byteAddr(IDX_PRESCALE), 32'h0, rd, er); `CHK(rd, 32'h5c)
    gap(2, n); `CHK(n, 10)
    wr(IDX_DIST_SEL, 32'h0);
    gap(2, n); `CHK(n, 6)
    for (k = 0; k < 6; k++) begin
      r = (k < 4) ? k : (k == 4) ? 259 : 4 + $urandom_range(40);
      wr(IDX_CNT_RESET, 32'h1);
      wr(IDX_REF_UPPER, 32'(r >> 8));
      wr(IDX_REF_LOWER, 32'(r & 255));
      wr(IDX_CNT_RESET, 32'h0);
      gap(0, n); `CHK(n, ((r == 0) ? 1 : r) * 6)
    end
    for (k = 0; k < 16; k++) begin
      m = k[2:0];
      b = k[3];
      if (m == 3'b000 || m == 3'b001 || m == 3'b111) mn = (k == 0) ? 3 : 3 + $urandom_range(17);
      else mn = 3 + $urandom_range(3);
      sw = (k == 10) ? mn - 1 : $urandom_range(mn - 1);
      wr(IDX_CNT_RESET, 32'h1);
      wr(IDX_PRESCALE, {25'h0, b, 1'b0, m, 2'b00});
      wr(IDX_SWALLOW, 32'(sw));
      wr(IDX_MAIN_LOWER, 32'(mn & 255));
      wr(IDX_MAIN_UPPER, 32'(mn >> 8));
      ph = (fbExp(m, 1'b0, 1, 1) != fbExp(m, 1'b0, 1, 0)) && sw != 0;
      apb(1'b0, byteAddr(IDX_STATUS), 32'h0, rd, er); `CHK(rd, {18'h0, ph, 13'h0})
      wr(IDX_CNT_RESET, 32'h0);
      gap(1, n); `CHK(n, fbExp(m, b, mn, sw) * 6)
    end
    wr(IDX_CNT_RESET, 32'h1);
    count(rc, fc); `CHK(rc + fc, 0)
    wr(IDX_CNT_RESET, 32'h0);
    wr(IDX_AB_RESET, 32'h1);
    count(rc, fc); `CHK({rc != 0, fc == 0}, 2'b11)
    wr(IDX_AB_RESET, 32'h0);
    count(rc, fc); `CHK(fc != 0, 1'b1)
    close_out();
  end
endmodule

bind pfrd_pll_dividers pfrd_pll_dividers_checker #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .reference_clock_input(reference_clock_input),
  .reference_clock_input_complement(reference_clock_input_complement), .first_clock_input(first_clock_input),
  .oscillator_clock_input(oscillator_clock_input), .pfdReferencePulse(pfdReferencePulse),
  .pfdFeedbackPulse(pfdFeedbackPulse), .distributionClock(distributionClock));
